// >>> rtl/ctr_envelope_decrypt_iv.sv
// Receive-path counter-mode decryptor with initialization vector builder.
`timescale 1ns/10ps
`default_nettype none
module ctr_envelope_decrypt_iv #(
  parameter int TBL_AW   = 8,
  parameter int TICK_DIV = ctr_decrypt_pkg::TICK_DIV_DEF
) (
  // Clock and reset.
  input  wire logic         clk_sys,
  input  wire logic         reset,
  // Register port.
  input  wire logic [7:0]   reg_addr,
  input  wire logic [31:0]  reg_wdata,
  input  wire logic         reg_wr,
  input  wire logic         reg_rd,
  output var  logic [31:0]  reg_rdata,
  // Envelope header from the receive buffer.
  input  wire logic         hdr_valid,
  input  wire logic [63:0]  hdr_data,
  input  wire logic [15:0]  hdr_llid,
  // Ciphertext blocks.
  input  wire logic         blk_valid,
  input  wire logic [127:0] blk_data,
  input  wire logic [15:0]  blk_ctrl,
  input  wire logic         blk_half,
  output var  logic         blk_ready,
  // Toward the output process.
  output var  logic         hdr_out_valid,
  output var  logic [63:0]  hdr_out_data,
  output var  logic         pt_valid,
  output var  logic [127:0] pt_data
);

  ////////////////////////////////////////////////////////////////////////////
  // State.

  typedef struct packed {
    ctr_decrypt_pkg::dec_state_t state;
    logic [7:0]   div;
    logic         tick;
    logic [47:0]  cclk;
    logic [31:0]  cclk_stg;
    logic [47:0]  stamp;
    logic [7:0]   tag;
    logic [31:0]  ctrl;
    logic [47:0]  mac_learn;
    logic [127:0] key_stg;
    logic [127:0] key_act;
    logic [31:0]  tbl_idx;
    logic [31:0]  tbl_lo;
    logic [127:0] ctr;
    logic [127:0] ks;
    logic         start;
    logic         blk_ready;
    logic         hdr_v;
    logic [63:0]  hdr_d;
    logic         pt_v;
    logic [127:0] pt_d;
    logic [31:0]  rdata;
  } dec_t;

  dec_t s_r;
  dec_t s_nxt;

  logic         tbl_wr;
  logic [47:0]  tbl_rdata;
  logic         core_done;
  logic [127:0] core_out;
  logic [127:0] ks_mask;
  logic [47:0]  station_addr;

  ////////////////////////////////////////////////////////////////////////////
  // Address table and forward cipher.

  assign tbl_wr = reg_wr && reg_addr == ctr_decrypt_pkg::OFF_TBL_HI;

  station_addr_table #(
    .AW (TBL_AW),
    .DW (ctr_decrypt_pkg::ADDR_W)
  ) u_table (
    .clk_sys (clk_sys),
    .wr_en   (tbl_wr),
    .wr_idx  (s_r.tbl_idx[TBL_AW-1:0]),
    .wr_data ({reg_wdata[15:0], s_r.tbl_lo}),
    .rd_idx  (hdr_llid[TBL_AW-1:0]),
    .rd_data (tbl_rdata)
  );

  block_cipher_fwd u_cipher (
    .clk_sys (clk_sys),
    .reset   (reset),
    .start   (s_r.start),
    .key     (s_r.key_act),
    .din     (s_r.ctr),
    .done    (core_done),
    .dout    (core_out)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Keystream mask: control-character bytes keep their ciphertext.

  for (genvar i = 0; i < 16; i++) begin : g_mask
    localparam int LO = 8 * i;
    assign ks_mask[LO +: 8] =
      (blk_ctrl[i] || (blk_half && LO < ctr_decrypt_pkg::QUAD_W)) ?
      8'h00 : 8'hff;
  end

  // Table select bit takes the table address, else the learned terminal address.
  assign station_addr = s_r.ctrl[ctr_decrypt_pkg::CTRL_TBL_BIT] ?
                        tbl_rdata : s_r.mac_learn;

  ////////////////////////////////////////////////////////////////////////////
  // Next state.

  always_comb begin
    s_nxt = s_r;
    s_nxt.start = 1'b0;
    s_nxt.hdr_v = 1'b0;
    s_nxt.pt_v = 1'b0;
    s_nxt.rdata = 32'h0000_0000;

    // Cipher clock runs on the MPCP tick, apart from MPCP time.
    s_nxt.tick = 1'b0;
    if (s_r.div == 8'(TICK_DIV - 1)) begin
      s_nxt.div = 8'h00;
      s_nxt.tick = 1'b1;
    end else begin
      s_nxt.div = s_r.div + 8'h01;
    end
    if (s_r.tick) begin
      s_nxt.cclk = s_r.cclk + 48'h1;
    end

    // Register writes.
    if (reg_wr) begin
      case (reg_addr)
        ctr_decrypt_pkg::OFF_CTRL:    s_nxt.ctrl = reg_wdata;
        ctr_decrypt_pkg::OFF_MAC_LO:  s_nxt.mac_learn[31:0] = reg_wdata;
        ctr_decrypt_pkg::OFF_MAC_HI:  s_nxt.mac_learn[47:32] = reg_wdata[15:0];
        ctr_decrypt_pkg::OFF_KEY0:    s_nxt.key_stg[127:96] = reg_wdata;
        ctr_decrypt_pkg::OFF_KEY1:    s_nxt.key_stg[95:64] = reg_wdata;
        ctr_decrypt_pkg::OFF_KEY2:    s_nxt.key_stg[63:32] = reg_wdata;
        ctr_decrypt_pkg::OFF_KEY3:    s_nxt.key_stg[31:0] = reg_wdata;
        ctr_decrypt_pkg::OFF_TBL_IDX: s_nxt.tbl_idx = reg_wdata;
        ctr_decrypt_pkg::OFF_TBL_LO:  s_nxt.tbl_lo = reg_wdata;
        ctr_decrypt_pkg::OFF_CCLK_LO: s_nxt.cclk_stg = reg_wdata;
        ctr_decrypt_pkg::OFF_CCLK_HI: begin
          s_nxt.cclk = {reg_wdata[15:0], s_r.cclk_stg};
        end
        default: ;
      endcase
    end

    // Register reads, answered in the next cycle only.
    if (reg_rd) begin
      case (reg_addr)
        ctr_decrypt_pkg::OFF_CTRL:    s_nxt.rdata = s_r.ctrl;
        ctr_decrypt_pkg::OFF_MAC_LO:  s_nxt.rdata = s_r.mac_learn[31:0];
        ctr_decrypt_pkg::OFF_MAC_HI:  s_nxt.rdata = {16'h0, s_r.mac_learn[47:32]};
        ctr_decrypt_pkg::OFF_TBL_IDX: s_nxt.rdata = s_r.tbl_idx;
        ctr_decrypt_pkg::OFF_TBL_LO:  s_nxt.rdata = s_r.tbl_lo;
        ctr_decrypt_pkg::OFF_STATUS:  s_nxt.rdata = {28'h0, s_r.state};
        ctr_decrypt_pkg::OFF_CCLK_LO: s_nxt.rdata = s_r.cclk[31:0];
        ctr_decrypt_pkg::OFF_CCLK_HI: s_nxt.rdata = {16'h0, s_r.cclk[47:32]};
        default:                      s_nxt.rdata = 32'h0000_0000;
      endcase
    end

    // Envelope state machine.
    case (s_r.state)
      ctr_decrypt_pkg::ST_IDLE: begin
        // Nothing to do until a start header arrives.
        s_nxt.state = ctr_decrypt_pkg::ST_IDLE;
      end
      ctr_decrypt_pkg::ST_BUILD: begin
        // Vector from channel tag, station address and latched cipher-clock stamp, ordinal zero, one cycle on.
        s_nxt.ctr   = {s_r.tag, station_addr, s_r.stamp,
                       24'h00_0000};
        s_nxt.start = 1'b1;
        s_nxt.state = ctr_decrypt_pkg::ST_GEN;
      end
      ctr_decrypt_pkg::ST_GEN: begin
        // Keystream is made before the ciphertext block is accepted.
        if (core_done) begin
          s_nxt.ks    = core_out;
          s_nxt.state = ctr_decrypt_pkg::ST_READY;
        end
      end
      ctr_decrypt_pkg::ST_READY: begin
        if (blk_valid) begin
          s_nxt.pt_v  = 1'b1;
          s_nxt.pt_d  = blk_data ^ (s_r.ks & ks_mask);
          s_nxt.ctr   = s_r.ctr + 128'h1;
          s_nxt.start = 1'b1;
          s_nxt.state = ctr_decrypt_pkg::ST_GEN;
        end
      end
      default: begin
        s_nxt.state = ctr_decrypt_pkg::ST_IDLE;
      end
    endcase

    // A start header restarts the envelope whatever came before.
    if (hdr_valid) begin
      s_nxt.hdr_v   = 1'b1;
      s_nxt.hdr_d   = hdr_data;
      s_nxt.stamp   = s_r.cclk;
      s_nxt.tag     = {s_r.ctrl[ctr_decrypt_pkg::CTRL_UP_BIT],
                       s_r.ctrl[ctr_decrypt_pkg::CTRL_CH_LSB +: 7]};
      s_nxt.key_act = s_r.key_stg;
      s_nxt.start   = 1'b0;
      s_nxt.state   = ctr_decrypt_pkg::ST_BUILD;
    end

    s_nxt.blk_ready = s_nxt.state == ctr_decrypt_pkg::ST_READY;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers.

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      s_r <= '0;
      s_r.state <= ctr_decrypt_pkg::ST_IDLE;
      s_r.ctrl <= ctr_decrypt_pkg::CTRL_RST;
      s_r.key_stg <= ctr_decrypt_pkg::KEY_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign reg_rdata     = s_r.rdata;
  assign blk_ready     = s_r.blk_ready;
  assign hdr_out_valid = s_r.hdr_v;
  assign hdr_out_data  = s_r.hdr_d;
  assign pt_valid      = s_r.pt_v;
  assign pt_data       = s_r.pt_d;

endmodule : ctr_envelope_decrypt_iv
`default_nettype wire

// >>> rtl/ctr_decrypt_pkg.sv
// Constants, register map and state codes for the counter-mode decryptor.
// Behaviour
// - Each counter block is ciphered forward and XOR-ed with its ciphertext block.
// - First counter equals the vector; each later counter is the previous plus one.
// - Odd last block carries one quad-word; only upper 64 keystream bits apply.
// - Per-block mask zeroes keystream at control characters so they pass unchanged.
// - Keystream may be computed ahead of ciphertext once counters are known.
// - Decrypt vector is built when a start header is seen in the receive path.
// - Vector and counters match those the encrypting side used for that envelope.
// - Vectors differ per envelope under one key so counters never repeat.
// - Vector comes from channel tag, station address, timestamp and block ordinal.
// - Channel tag: bit 127 direction, upstream one; bits 126:120 channel number.
// - Station address is the encrypting side's PON port MAC address.
// - Network unit decrypting downstream uses the terminal MAC learned at registration.
// - Central terminal decrypting upstream looks up the MAC registered for the LLID.
// - Timestamp latches the cipher clock when the start header is observed.
// - Cipher clock advances with the MPCP clock yet is a separate counter.
// - Block ordinal clears at a header and rises by one per later block.
// - Cipher clock is a 48-bit counter.
// - Cipher blocks are 128 bits, two quad-words of payload.
// - Envelope header passes around decryption unchanged.
// - Vector is built within one MPCP clock cycle of the header.
package ctr_decrypt_pkg;

  // Field layout of the initialization vector.
  localparam int TAG_W   = 8;
  localparam int ADDR_W  = 48;
  localparam int CCLK_W  = 48;
  localparam int ORD_W   = 24;
  localparam int BLOCK_W = 128;
  localparam int QUAD_W  = 64;
  localparam int TAG_DIR_BIT = 7;

  // Register byte offsets.
  localparam logic [7:0] OFF_CTRL    = 8'h00;
  localparam logic [7:0] OFF_MAC_LO  = 8'h04;
  localparam logic [7:0] OFF_MAC_HI  = 8'h08;
  localparam logic [7:0] OFF_KEY0    = 8'h0c;
  localparam logic [7:0] OFF_KEY1    = 8'h10;
  localparam logic [7:0] OFF_KEY2    = 8'h14;
  localparam logic [7:0] OFF_KEY3    = 8'h18;
  localparam logic [7:0] OFF_TBL_IDX = 8'h1c;
  localparam logic [7:0] OFF_TBL_LO  = 8'h20;
  localparam logic [7:0] OFF_TBL_HI  = 8'h24;
  localparam logic [7:0] OFF_STATUS  = 8'h28;
  localparam logic [7:0] OFF_CCLK_LO = 8'h2c;
  localparam logic [7:0] OFF_CCLK_HI = 8'h30;

  // Control field positions and reset values.
  localparam int CTRL_UP_BIT   = 0;
  localparam int CTRL_TBL_BIT  = 1;
  localparam int CTRL_CH_LSB   = 8;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [BLOCK_W-1:0] KEY_RST = 128'h0;

  // Cipher clock divider default, in system cycles per MPCP tick.
  localparam int TICK_DIV_DEF = 1;

  // Cipher core round count.
  localparam logic [3:0] ROUNDS = 4'ha;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_BUILD = 4'b0010,
    ST_GEN   = 4'b0100,
    ST_READY = 4'b1000
  } dec_state_t;

endpackage : ctr_decrypt_pkg

// >>> rtl/station_addr_table.sv
// Table of station addresses indexed by logical link, registered read.
`timescale 1ns/10ps
`default_nettype none
module station_addr_table #(
  parameter int AW = 8,
  parameter int DW = 48
) (
  // Clock.
  input  wire logic          clk_sys,
  // Write port.
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_idx,
  input  wire logic [DW-1:0] wr_data,
  // Read port.
  input  wire logic [AW-1:0] rd_idx,
  output var  logic [DW-1:0] rd_data
);

  logic [DW-1:0] mem [2**AW];

  always_ff @(posedge clk_sys) begin
    if (wr_en) begin
      mem[wr_idx] <= wr_data;
    end
    rd_data <= mem[rd_idx];
  end

endmodule : station_addr_table
`default_nettype wire

// >>> rtl/block_cipher_fwd.sv
// Iterative forward block cipher, one round per clock, key expanded on the fly.
`timescale 1ns/10ps
`default_nettype none
module block_cipher_fwd (
  // Clock and reset.
  input  wire logic         clk_sys,
  input  wire logic         reset,
  // Request.
  input  wire logic         start,
  input  wire logic [127:0] key,
  input  wire logic [127:0] din,
  // Answer.
  output var  logic         done,
  output var  logic [127:0] dout
);

  function automatic logic [7:0] gmul(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] p;
    logic [7:0] x;
    p = 8'h00;
    x = a;
    for (int i = 0; i < 8; i++) begin
      if (b[i]) p = p ^ x;
      x = {x[6:0], 1'b0} ^ (x[7] ? 8'h1b : 8'h00);
    end
    return p;
  endfunction : gmul

  // Substitution by field inverse (x to the 254th) and the affine map.
  function automatic logic [7:0] sbox(input logic [7:0] a);
    logic [7:0] p;
    logic [7:0] r;
    p = a;
    r = 8'h01;
    for (int i = 0; i < 7; i++) begin
      p = gmul(p, p);
      r = gmul(r, p);
    end
    return r ^ {r[6:0], r[7]} ^ {r[5:0], r[7:6]} ^ {r[4:0], r[7:5]}
           ^ {r[3:0], r[7:4]} ^ 8'h63;
  endfunction : sbox

  function automatic logic [127:0] round_fn(input logic [127:0] s,
                                            input logic       last);
    logic [7:0] b [16];
    logic [7:0] t [16];
    logic [127:0] o;
    for (int i = 0; i < 16; i++) b[i] = sbox(s[127-8*i -: 8]);
    for (int c = 0; c < 4; c++) begin
      for (int r = 0; r < 4; r++) t[4*c+r] = b[4*((c+r)%4)+r];
    end
    for (int c = 0; c < 4; c++) begin
      for (int r = 0; r < 4; r++) begin
        o[127-8*(4*c+r) -: 8] = last ? t[4*c+r] :
          gmul(t[4*c+r], 8'h02) ^ gmul(t[4*c+(r+1)%4], 8'h03)
          ^ t[4*c+(r+2)%4] ^ t[4*c+(r+3)%4];
      end
    end
    return o;
  endfunction : round_fn

  function automatic logic [127:0] next_key(input logic [127:0] k,
                                            input logic [7:0]   rc);
    logic [31:0] w [4];
    logic [31:0] g;
    for (int i = 0; i < 4; i++) w[i] = k[127-32*i -: 32];
    g = {sbox(w[3][23:16]) ^ rc, sbox(w[3][15:8]), sbox(w[3][7:0]),
         sbox(w[3][31:24])};
    w[0] = w[0] ^ g;
    w[1] = w[1] ^ w[0];
    w[2] = w[2] ^ w[1];
    w[3] = w[3] ^ w[2];
    return {w[0], w[1], w[2], w[3]};
  endfunction : next_key

  typedef struct packed {
    logic [127:0] st;
    logic [127:0] rk;
    logic [7:0]   rc;
    logic [3:0]   rnd;
    logic         busy;
    logic         done;
  } core_t;

  core_t r_r;
  core_t r_nxt;
  logic [127:0] k_nx;

  always_comb begin
    r_nxt = r_r;
    r_nxt.done = 1'b0;
    k_nx = next_key(r_r.rk, r_r.rc);
    if (start) begin
      r_nxt.st = din ^ key;
      r_nxt.rk = key;
      r_nxt.rc = 8'h01;
      r_nxt.rnd = 4'h1;
      r_nxt.busy = 1'b1;
    end else if (r_r.busy) begin
      r_nxt.st = round_fn(r_r.st, r_r.rnd == ctr_decrypt_pkg::ROUNDS) ^ k_nx;
      r_nxt.rk = k_nx;
      r_nxt.rc = gmul(r_r.rc, 8'h02);
      r_nxt.rnd = r_r.rnd + 4'h1;
      if (r_r.rnd == ctr_decrypt_pkg::ROUNDS) begin
        r_nxt.busy = 1'b0;
        r_nxt.done = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      r_r <= '0;
    end else begin
      r_r <= r_nxt;
    end
  end

  assign done = r_r.done;
  assign dout = r_r.st;

endmodule : block_cipher_fwd
`default_nettype wire

// >>> verif/ctr_dec_properties.sv
// Port assertions for the counter-mode decryptor.
`timescale 1ns/10ps
`default_nettype none
module ctr_dec_props (
  // Clock and reset.
  input wire logic         clk_sys,
  input wire logic         reset,
  // Stream.
  input wire logic         hdr_valid,
  input wire logic [63:0]  hdr_data,
  input wire logic         blk_valid,
  input wire logic [127:0] blk_data,
  input wire logic [15:0]  blk_ctrl,
  input wire logic         blk_half,
  input wire logic         blk_ready,
  input wire logic         hdr_out_valid,
  input wire logic [63:0]  hdr_out_data,
  input wire logic         pt_valid,
  input wire logic [127:0] pt_data
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);
  wire take = blk_valid && blk_ready;

  hdr_pass_a: assert property (hdr_valid |=> hdr_out_valid &&
    hdr_out_data == $past(hdr_data)) else $error("header altered");
  hdr_cause_a: assert property (hdr_out_valid |-> $past(hdr_valid))
    else $error("stray header");
  pt_resp_a: assert property (take |=> pt_valid)
    else $error("no plaintext");
  pt_cause_a: assert property (pt_valid |-> $past(take))
    else $error("stray plaintext");
  ctrl_pass_a: assert property (take && blk_ctrl[15] |=>
    pt_data[127:120] == $past(blk_data[127:120])) else $error("ctrl lost");
  half_pass_a: assert property (take && blk_half |=>
    pt_data[63:0] == $past(blk_data[63:0])) else $error("half lost");
  iv_time_a: assert property (hdr_valid |=> !blk_ready ##13 blk_ready)
    else $error("vector late");
  next_ctr_a: assert property (take |=> !blk_ready ##12 blk_ready)
    else $error("counter late");
  cover property (take && blk_half);
  cover property (take && blk_ctrl != 16'h0000);
  cover property (hdr_valid);
endmodule : ctr_dec_props

bind ctr_envelope_decrypt_iv ctr_dec_props u_props (
  .clk_sys(clk_sys), .reset(reset), .hdr_valid(hdr_valid),
  .hdr_data(hdr_data), .blk_valid(blk_valid), .blk_data(blk_data),
  .blk_ctrl(blk_ctrl), .blk_half(blk_half), .blk_ready(blk_ready),
  .hdr_out_valid(hdr_out_valid), .hdr_out_data(hdr_out_data),
  .pt_valid(pt_valid), .pt_data(pt_data));
`default_nettype wire

// >>> verif/env_rx_model.sv
// Model of the envelope receive buffer feeding the decryptor.
`timescale 1ns/10ps
`default_nettype none
module env_rx_model (
  // Clock.
  input  wire logic         clk_sys,
  // Toward the decryptor.
  input  wire logic         blk_ready,
  output var  logic         hdr_valid,
  output var  logic [63:0]  hdr_data,
  output var  logic [15:0]  hdr_llid,
  output var  logic         blk_valid,
  output var  logic [127:0] blk_data,
  output var  logic [15:0]  blk_ctrl,
  output var  logic         blk_half
);
  initial begin
    hdr_valid = 1'b0;
    hdr_data  = 64'h0;
    hdr_llid  = 16'h0;
    blk_valid = 1'b0;
    blk_data  = 128'h0;
    blk_ctrl  = 16'h0;
    blk_half  = 1'b0;
  end

  // Released data lines show the inverse of their last value; llid, ctrl and half lines hold.
  task send_hdr(input logic [63:0] d, input logic [15:0] l);
    @(posedge clk_sys);
    hdr_valid <= 1'b1;
    hdr_data  <= d;
    hdr_llid  <= l;
    @(posedge clk_sys);
    hdr_valid <= 1'b0;
    hdr_data  <= ~d;
  endtask : send_hdr

  task send_blk(input logic [127:0] d, input logic [15:0] c,
                input logic h, input int stall);
    int n;
    repeat (stall) @(posedge clk_sys);
    @(posedge clk_sys);
    blk_valid <= 1'b1;
    blk_data  <= d;
    blk_ctrl  <= c;
    blk_half  <= h;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (!blk_ready && n < 200);
    blk_valid <= 1'b0;
    blk_data  <= ~d;
  endtask : send_blk
endmodule : env_rx_model
`default_nettype wire

// >>> verif/tb.sv
// Self-checking bench for the counter-mode decryptor.
`timescale 1ns/10ps
`default_nettype none
module tb;
  typedef struct packed {
    logic         cap;
    logic [2:0]   slot;
    logic [127:0] v;
  } note_t;
  logic         clk_sys   = 1'b0;
  logic         reset     = 1'b1;
  logic [7:0]   reg_addr  = 8'h00;
  logic [31:0]  reg_wdata = 32'h0;
  logic         reg_wr    = 1'b0;
  logic         reg_rd    = 1'b0;
  logic [31:0]  reg_rdata;
  logic         hdr_valid, blk_valid, blk_half, blk_ready;
  logic         hdr_out_valid, pt_valid;
  logic [63:0]  hdr_data, hdr_out_data;
  logic [15:0]  hdr_llid, blk_ctrl;
  logic [127:0] blk_data, pt_data;
  logic [127:0] ks [0:7];
  note_t        pt_q[$];
  logic [63:0]  hq[$];
  logic [31:0]  rq[$];
  logic         rd_pend = 1'b0;
  note_t        nt;
  int           error_cnt = 0;
  int           samples_checked = 0;

  always #4 clk_sys = ~clk_sys;

  ctr_envelope_decrypt_iv #(.TBL_AW(8), .TICK_DIV(1)) dut (
    .clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .hdr_valid(hdr_valid), .hdr_data(hdr_data),
    .hdr_llid(hdr_llid), .blk_valid(blk_valid), .blk_data(blk_data),
    .blk_ctrl(blk_ctrl), .blk_half(blk_half), .blk_ready(blk_ready),
    .hdr_out_valid(hdr_out_valid), .hdr_out_data(hdr_out_data),
    .pt_valid(pt_valid), .pt_data(pt_data));

  env_rx_model pm (
    .clk_sys(clk_sys), .blk_ready(blk_ready), .hdr_valid(hdr_valid),
    .hdr_data(hdr_data), .hdr_llid(hdr_llid), .blk_valid(blk_valid),
    .blk_data(blk_data), .blk_ctrl(blk_ctrl), .blk_half(blk_half));

  ////////////////////////////////////////////////////////////////////////////
  task chk(input string n, input logic [127:0] e, input logic [127:0] s);
    samples_checked++;
    if (s !== e) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask : chk

  task chk_ne(input logic [127:0] a, input logic [127:0] b);
    samples_checked++;
    if (a === b) begin
      error_cnt++;
      $display("BAD keystream exp differ got %h", b);
    end
  endtask : chk_ne

  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr

  task rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    rq.push_back(e);
    @(posedge clk_sys);
    reg_rd <= 1'b0;
  endtask : rd

  // Cipher clock reloads identically so replayed envelopes share a stamp.
  task env(input logic [31:0] ctl, input int nb, input logic cap,
           input int s0, input logic odd, input int stall);
    logic [127:0] ct, m;
    logic [63:0]  hd;
    logic [15:0]  c;
    logic         h;
    wr(8'h00, ctl);
    wr(8'h2c, 32'h1234_5678);
    wr(8'h30, 32'h0000_9abc);
    repeat (16) @(posedge clk_sys);
    hd = {$urandom, $urandom};
    hq.push_back(hd);
    pm.send_hdr(hd, 16'h0005);
    for (int i = 0; i < nb; i++) begin
      ct = cap ? 128'h0 : {$urandom, $urandom, $urandom, $urandom};
      c  = cap ? 16'h0 : 16'($urandom);
      h  = odd && (i == nb - 1);
      m  = ks[s0+i];
      for (int b = 0; b < 16; b++) begin
        if (c[b] || (h && b < 8)) m[8*b+:8] = 8'h00;
      end
      pt_q.push_back('{cap, 3'(s0 + i), ct ^ m});
      pm.send_blk(ct, c, h, stall);
    end
    for (int k = 0; k < 100 && pt_q.size() > 0; k++) @(posedge clk_sys);
    chk("pt left", 128'h0, 128'(pt_q.size()));
  endtask : env

  task report_and_stop;
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : report_and_stop

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk_sys) begin
    if (hdr_out_valid) begin
      chk("hdr", {64'h0, hq.size() ? hq.pop_front() : ~hdr_out_data},
          {64'h0, hdr_out_data});
    end
    if (pt_valid) begin
      nt = '{1'b0, 3'h0, ~pt_data};
      if (pt_q.size() > 0) nt = pt_q.pop_front();
      if (nt.cap) ks[nt.slot] = pt_data;
      else chk("pt", nt.v, pt_data);
    end
    // Read data stand only in the cycle after the strobe, else zero.
    if (rd_pend) begin
      chk("reg", {96'h0, rq.size() ? rq.pop_front() : ~reg_rdata},
          {96'h0, reg_rdata});
    end else if (!reset) begin
      chk("reg idle", 128'h0, {96'h0, reg_rdata});
    end
    rd_pend <= reg_rd;
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    error_cnt++;
    report_and_stop;
  end

  initial begin
    void'($urandom(32'h67ff600d));
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    rd(8'h28, 32'h1);
    rd(8'h00, 32'h0);
    for (int k = 0; k < 4; k++) wr(8'h0c + 8'(4 * k), $urandom);
    rd(8'h0c, 32'h0);
    rd(8'h40, 32'h0);
    wr(8'h04, 32'h0a0b_0c0d);
    wr(8'h08, 32'h0000_0e0f);
    env(32'h0, 3, 1'b1, 0, 1'b0, 0);
    chk_ne(ks[0], ks[1]);
    chk_ne(ks[1], ks[2]);
    env(32'h0, 3, 1'b0, 0, 1'b1, 3);
    wr(8'h1c, 32'h5);
    wr(8'h20, 32'h0a0b_0c0d);
    wr(8'h24, 32'h0000_0e0f);
    env(32'h2, 2, 1'b0, 0, 1'b0, 0);
    wr(8'h24, 32'h0000_0e0e);
    env(32'h2, 1, 1'b1, 4, 1'b0, 0);
    chk_ne(ks[0], ks[4]);
    env(32'h0500, 1, 1'b1, 5, 1'b0, 0);
    chk_ne(ks[0], ks[5]);
    env(32'h1, 1, 1'b1, 6, 1'b0, 0);
    chk_ne(ks[0], ks[6]);
    wr(8'h0c, 32'h0);
    env(32'h0, 1, 1'b1, 7, 1'b0, 0);
    chk_ne(ks[0], ks[7]);
    report_and_stop;
  end
endmodule : tb
`default_nettype wire
